// >>> serial_port_pkg.sv
// Constants shared by the serial port status block
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned BAUD_RATE       = 19_200;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int          CYC_W           = 11;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS2    = 4'h0;
  localparam logic [3:0] OFS_CONTROL    = 4'h1;
  localparam logic [3:0] OFS_RX_DATA    = 4'h2;
  localparam logic [3:0] OFS_STATUS1    = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLEAR  = 4'h5;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int S2_BREAK_FLAG   = 7;
  localparam int S2_EDGE_FLAG    = 6;
  localparam int S2_INVERT       = 4;
  localparam int S2_IDLE_REPORT  = 3;
  localparam int S2_LONG_BRK_TX  = 2;
  localparam int S2_LONG_BRK_DET = 1;
  localparam int S2_ACTIVE       = 0;
  localparam int CTL_NINE_BIT    = 0;
  localparam int CTL_STANDBY     = 1;
  localparam int CTL_SEND_BREAK  = 2;
  localparam int S1_RX_FULL      = 0;
  localparam int S1_FRAME_ERR    = 1;
  localparam int S1_IDLE         = 2;
  localparam int IRQ_BREAK       = 0;
  localparam int IRQ_EDGE        = 1;
  localparam int IRQ_RX_FULL     = 2;
  localparam int IRQ_FRAME_ERR   = 3;
  localparam int IRQ_IDLE        = 4;
  localparam int IRQ_W           = 5;

  // ----------------------------------------------------------------
  // Reset values and bit counts
  // ----------------------------------------------------------------
  localparam logic [7:0]       STATUS2_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET     = 5'h00;
  localparam logic             LINE_IDLE     = 1'b1;
  localparam logic [3:0]       CHAR_BITS     = 4'hA;
  localparam logic [3:0]       BRK_DET_SHORT = 4'hA;
  localparam logic [3:0]       BRK_DET_LONG  = 4'hB;
  localparam logic [3:0]       BRK_TX_SHORT  = 4'hA;
  localparam logic [3:0]       BRK_TX_LONG   = 4'hD;
  localparam logic [3:0]       DATA_BITS     = 4'h8;

endpackage : serial_port_pkg

// >>> serial_rx_sync.sv
// Three-stage receive pin synchroniser with agreement filter
`timescale 1ns/1ps
module serial_rx_sync (
  input  wire logic clk_sys,   // System clock
  input  wire logic rst,       // Async reset, active high
  input  wire logic pin_in,    // Raw receive pin
  output logic      level_out  // Filtered level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_reg <= serial_port_pkg::LINE_IDLE;
      s2_reg <= serial_port_pkg::LINE_IDLE;
      s3_reg <= serial_port_pkg::LINE_IDLE;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level moves only when the two settled stages agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_out <= serial_port_pkg::LINE_IDLE;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end

endmodule : serial_rx_sync

// >>> serial_status_two.sv
// Serial port receive status, break detection and break transmit
`timescale 1ns/1ps
module serial_status_two (
  input  wire logic       clk_sys,    // System clock, 20 MHz
  input  wire logic       rst,        // Async reset, active high
  input  wire logic [3:0] reg_addr,   // Register offset
  input  wire logic [7:0] reg_wdata,  // Write data
  input  wire logic       reg_wr,     // Write strobe
  input  wire logic       reg_rd,     // Read strobe
  output logic      [7:0] reg_rdata,  // Read data, cycle after strobe
  input  wire logic       rx_pin,     // Receive pin
  output logic            tx_pin,     // Transmit pin
  output logic            irq         // Level interrupt
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  localparam logic [serial_port_pkg::CYC_W-1:0] BIT_LAST =
    serial_port_pkg::CYC_W'(serial_port_pkg::BIT_CYCLES - 1);
  localparam logic [serial_port_pkg::CYC_W-1:0] HALF_LAST =
    serial_port_pkg::CYC_W'(serial_port_pkg::HALF_BIT_CYCLES - 1);

  function automatic logic [3:0] break_threshold(input logic long_det, input logic nine);
    break_threshold = (long_det ? serial_port_pkg::BRK_DET_LONG
                                : serial_port_pkg::BRK_DET_SHORT) + {3'h0, nine};
  endfunction : break_threshold

  function automatic logic [3:0] char_bits(input logic nine);
    char_bits = serial_port_pkg::CHAR_BITS + {3'h0, nine};
  endfunction : char_bits

  function automatic logic [3:0] tx_break_bits(input logic long_tx, input logic nine);
    tx_break_bits = (long_tx ? serial_port_pkg::BRK_TX_LONG
                             : serial_port_pkg::BRK_TX_SHORT) + {3'h0, nine};
  endfunction : tx_break_bits

  logic                                rx_level;
  logic                                rx_line;
  logic                                rx_prev_reg;
  logic                                break_flag_reg;
  logic                                edge_flag_reg;
  logic                                invert_reg;
  logic                                idle_report_reg;
  logic                                long_tx_reg;
  logic                                long_det_reg;
  logic                                active_reg;
  logic                                nine_bit_reg;
  logic                                standby_reg;
  logic                                rx_full_reg;
  logic                                frame_err_reg;
  logic                                idle_flag_reg;
  logic                                idle_armed_reg;
  logic [7:0]                          rx_data_reg;
  logic [serial_port_pkg::CYC_W-1:0]   low_cyc_reg;
  logic [3:0]                          low_bits_reg;
  logic [serial_port_pkg::CYC_W-1:0]   high_cyc_reg;
  logic [3:0]                          high_bits_reg;
  rx_state_e                           rx_state_reg;
  logic [serial_port_pkg::CYC_W-1:0]   rx_cyc_reg;
  logic [3:0]                          rx_idx_reg;
  logic [8:0]                          rx_shift_reg;
  logic                                tx_busy_reg;
  logic [serial_port_pkg::CYC_W-1:0]   tx_cyc_reg;
  logic [3:0]                          tx_bits_reg;
  logic [3:0]                          tx_len_reg;
  logic [serial_port_pkg::IRQ_W-1:0]   irq_status_reg;
  logic [serial_port_pkg::IRQ_W-1:0]   irq_enable_reg;
  logic                                wr_status2;
  logic                                wr_control;
  logic                                rd_rx_data;
  logic                                rx_fall;
  logic                                low_tick;
  logic                                high_tick;
  logic                                break_event;
  logic                                idle_line_event;
  logic                                idle_event;
  logic                                start_valid;
  logic                                char_done;
  logic                                rx_full_event;
  logic                                frame_err_event;
  logic                                tx_start;
  logic [serial_port_pkg::IRQ_W-1:0]   irq_events;

  // ----------------------------------------------------------------
  // Receive input conditioning
  // ----------------------------------------------------------------
  serial_rx_sync u_rx_sync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_in    (rx_pin),
    .level_out (rx_level)
  );

  assign rx_line = rx_level ^ invert_reg;

  // Toggling the invert bit can itself look like an edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_prev_reg <= serial_port_pkg::LINE_IDLE;
    end else begin
      rx_prev_reg <= rx_line;
    end
  end

  assign rx_fall = rx_prev_reg & ~rx_line;

  // ----------------------------------------------------------------
  // Line level duration counters
  // ----------------------------------------------------------------
  assign low_tick  = ~rx_line & (low_cyc_reg == BIT_LAST);
  assign high_tick = rx_line & (high_cyc_reg == BIT_LAST);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cyc_reg   <= '0;
      low_bits_reg  <= '0;
      high_cyc_reg  <= '0;
      high_bits_reg <= '0;
    end else if (rx_line) begin
      low_cyc_reg  <= '0;
      low_bits_reg <= '0;
      high_cyc_reg <= high_tick ? '0 : high_cyc_reg + 1'b1;
      if (high_tick && high_bits_reg != 4'hF) begin
        high_bits_reg <= high_bits_reg + 4'h1;
      end
    end else begin
      high_cyc_reg  <= '0;
      high_bits_reg <= '0;
      low_cyc_reg   <= low_tick ? '0 : low_cyc_reg + 1'b1;
      if (low_tick && low_bits_reg != 4'hF) begin
        low_bits_reg <= low_bits_reg + 4'h1;
      end
    end
  end

  assign break_event = long_det_reg & low_tick &
    (low_bits_reg == break_threshold(long_det_reg, nine_bit_reg) - 4'h1);
  // Frame length follows the nine-bit mode
  assign idle_line_event = high_tick &
    (high_bits_reg == char_bits(nine_bit_reg) - 4'h1);
  assign idle_event = idle_line_event & idle_armed_reg &
    (~standby_reg | idle_report_reg);

  // ----------------------------------------------------------------
  // Character receiver
  // ----------------------------------------------------------------
  assign start_valid = (rx_state_reg == RX_START) & (rx_cyc_reg == HALF_LAST) & ~rx_line;
  assign char_done   = (rx_state_reg == RX_STOP) & (rx_cyc_reg == BIT_LAST);
  // Standby keeps characters out of the buffer
  assign rx_full_event   = char_done & ~long_det_reg & ~standby_reg;
  // Stop bit check uses no transmit setting
  assign frame_err_event = rx_full_event & ~rx_line;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_cyc_reg   <= '0;
      rx_idx_reg   <= '0;
      rx_shift_reg <= '0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_cyc_reg <= '0;
          if (!rx_line) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          rx_cyc_reg <= rx_cyc_reg + 1'b1;
          if (rx_cyc_reg == HALF_LAST) begin
            rx_cyc_reg   <= '0;
            rx_idx_reg   <= '0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          rx_cyc_reg <= rx_cyc_reg + 1'b1;
          if (rx_cyc_reg == BIT_LAST) begin
            rx_cyc_reg   <= '0;
            rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
            rx_idx_reg   <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == serial_port_pkg::DATA_BITS - {3'h0, ~nine_bit_reg}) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          rx_cyc_reg <= rx_cyc_reg + 1'b1;
          if (rx_cyc_reg == BIT_LAST) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register decode and status flags
  // ----------------------------------------------------------------
  assign wr_status2 = reg_wr & (reg_addr == serial_port_pkg::OFS_STATUS2);
  assign wr_control = reg_wr & (reg_addr == serial_port_pkg::OFS_CONTROL);
  assign rd_rx_data = reg_rd & (reg_addr == serial_port_pkg::OFS_RX_DATA);

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      break_flag_reg <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_BREAK_FLAG];
      edge_flag_reg  <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_EDGE_FLAG];
    end else begin
      if (break_event) begin
        break_flag_reg <= 1'b1;
      end else if (wr_status2 && reg_wdata[serial_port_pkg::S2_BREAK_FLAG]) begin
        break_flag_reg <= 1'b0;
      end
      if (rx_fall) begin
        edge_flag_reg <= 1'b1;
      end else if (wr_status2 && reg_wdata[serial_port_pkg::S2_EDGE_FLAG]) begin
        edge_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      invert_reg      <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_INVERT];
      idle_report_reg <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_IDLE_REPORT];
      long_tx_reg     <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_LONG_BRK_TX];
      long_det_reg    <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_LONG_BRK_DET];
    end else if (wr_status2) begin
      invert_reg      <= reg_wdata[serial_port_pkg::S2_INVERT];
      idle_report_reg <= reg_wdata[serial_port_pkg::S2_IDLE_REPORT];
      long_tx_reg     <= reg_wdata[serial_port_pkg::S2_LONG_BRK_TX];
      long_det_reg    <= reg_wdata[serial_port_pkg::S2_LONG_BRK_DET];
    end
  end

  // Read-only; no write path reaches it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_reg <= serial_port_pkg::STATUS2_RESET[serial_port_pkg::S2_ACTIVE];
    end else if (start_valid) begin
      active_reg <= 1'b1;
    end else if (idle_line_event) begin
      active_reg <= 1'b0;
    end
  end

  // Idle wakes the receiver out of standby
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nine_bit_reg <= 1'b0;
      standby_reg  <= 1'b0;
    end else if (wr_control) begin
      nine_bit_reg <= reg_wdata[serial_port_pkg::CTL_NINE_BIT];
      standby_reg  <= reg_wdata[serial_port_pkg::CTL_STANDBY];
    end else if (idle_line_event) begin
      standby_reg <= 1'b0;
    end
  end

  // Reading received data clears the receive flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_full_reg    <= 1'b0;
      frame_err_reg  <= 1'b0;
      idle_flag_reg  <= 1'b0;
      idle_armed_reg <= 1'b0;
      rx_data_reg    <= '0;
    end else begin
      if (rx_full_event) begin
        rx_full_reg <= 1'b1;
        rx_data_reg <= nine_bit_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
      end else if (rd_rx_data) begin
        rx_full_reg <= 1'b0;
      end
      if (frame_err_event) begin
        frame_err_reg <= 1'b1;
      end else if (rd_rx_data) begin
        frame_err_reg <= 1'b0;
      end
      if (idle_event) begin
        idle_flag_reg <= 1'b1;
      end else if (rd_rx_data) begin
        idle_flag_reg <= 1'b0;
      end
      if (char_done) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_line_event) begin
        idle_armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Break transmitter
  // ----------------------------------------------------------------
  assign tx_start = wr_control & reg_wdata[serial_port_pkg::CTL_SEND_BREAK] & ~tx_busy_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_busy_reg <= 1'b0;
      tx_cyc_reg  <= '0;
      tx_bits_reg <= '0;
      tx_len_reg  <= '0;
      tx_pin      <= serial_port_pkg::LINE_IDLE;
    end else if (tx_start) begin
      tx_busy_reg <= 1'b1;
      tx_cyc_reg  <= '0;
      tx_bits_reg <= '0;
      tx_len_reg  <= tx_break_bits(long_tx_reg, nine_bit_reg);
      tx_pin      <= 1'b0;
    end else if (tx_busy_reg) begin
      tx_cyc_reg <= (tx_cyc_reg == BIT_LAST) ? '0 : tx_cyc_reg + 1'b1;
      if (tx_cyc_reg == BIT_LAST) begin
        tx_bits_reg <= tx_bits_reg + 4'h1;
        if (tx_bits_reg == tx_len_reg - 4'h1) begin
          tx_busy_reg <= 1'b0;
          tx_pin      <= serial_port_pkg::LINE_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and read data
  // ----------------------------------------------------------------
  assign irq_events = {idle_event, frame_err_event, rx_full_event, rx_fall, break_event};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_status_reg <= serial_port_pkg::IRQ_RESET;
      irq_enable_reg <= serial_port_pkg::IRQ_RESET;
      irq            <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == serial_port_pkg::OFS_IRQ_CLEAR) begin
        irq_status_reg <= (irq_status_reg & ~reg_wdata[serial_port_pkg::IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
      if (reg_wr && reg_addr == serial_port_pkg::OFS_IRQ_ENABLE) begin
        irq_enable_reg <= reg_wdata[serial_port_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        serial_port_pkg::OFS_STATUS2:    reg_rdata <= {break_flag_reg, edge_flag_reg, 1'b0,
          invert_reg, idle_report_reg, long_tx_reg, long_det_reg, active_reg};
        serial_port_pkg::OFS_CONTROL:    reg_rdata <= {6'h00, standby_reg, nine_bit_reg};
        serial_port_pkg::OFS_RX_DATA:    reg_rdata <= rx_data_reg;
        serial_port_pkg::OFS_STATUS1:    reg_rdata <= {5'h00, idle_flag_reg, frame_err_reg,
          rx_full_reg};
        serial_port_pkg::OFS_IRQ_STATUS: reg_rdata <= {3'h0, irq_status_reg};
        serial_port_pkg::OFS_IRQ_ENABLE: reg_rdata <= {3'h0, irq_enable_reg};
        default:                         reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_tx_begin;
    tx_start;
  endsequence
  sequence s_tx_low;
    !tx_pin [*8];
  endsequence

  property p_break_set;
    break_event |=> break_flag_reg;
  endproperty
  a_break_set: assert property (p_break_set) else $error("break flag not set");

  property p_break_hold;
    break_flag_reg && !(wr_status2 && reg_wdata[7]) |=> break_flag_reg;
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("break flag lost");

  property p_edge_set;
    rx_fall |=> edge_flag_reg && $past(rx_line, 2) && !$past(rx_line);
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag missed");

  property p_edge_hold;
    edge_flag_reg && !(wr_status2 && reg_wdata[6]) |=> edge_flag_reg;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");

  property p_invert_start;
    rx_state_reg == RX_IDLE && (rx_level == invert_reg) |=> rx_state_reg == RX_START;
  endproperty
  a_invert_start: assert property (p_invert_start) else $error("inverted start missed");

  property p_standby_idle;
    idle_line_event && standby_reg && !idle_report_reg && !idle_flag_reg |=> !idle_flag_reg;
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("idle set in standby");

  property p_tx_break;
    s_tx_begin |=> s_tx_low ##0
      (tx_len_reg == tx_break_bits($past(long_tx_reg, 8), $past(nine_bit_reg, 8)));
  endproperty
  a_tx_break: assert property (p_tx_break) else $error("break length wrong");

  property p_no_full;
    long_det_reg |=> !$rose(rx_full_reg) && !$rose(frame_err_reg);
  endproperty
  a_no_full: assert property (p_no_full) else $error("flag set with long detect");

  property p_active_set;
    start_valid |=> active_reg;
  endproperty
  a_active_set: assert property (p_active_set) else $error("active flag not set");

  property p_active_clear;
    idle_line_event |=> !active_reg;
  endproperty
  a_active_clear: assert property (p_active_clear) else $error("active flag not cleared");

endmodule : serial_status_two

// >>> serial_node.sv
// Remote serial node model that drives the receive line
`timescale 1ns/1ps
module serial_node (
  output logic line  // Serial line into the block
);
  localparam realtime BIT_NS = serial_port_pkg::BIT_CYCLES * 50.0;

  initial line = serial_port_pkg::LINE_IDLE;

  task automatic send_frame(input logic [7:0] d);
    line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line = d[i];
      #(BIT_NS);
    end
    line = 1'b1;
    #(BIT_NS);
  endtask : send_frame

  // Line returns high, so the block sees a clean idle after the break
  task automatic send_low(input int bits);
    line = 1'b0;
    #(BIT_NS * bits);
    line = 1'b1;
  endtask : send_low
endmodule : serial_node

// >>> serial_status_two_bench.sv
// Self-checking bench for the serial status register block
`timescale 1ns/1ps
module serial_status_two_bench;
  localparam int BIT = serial_port_pkg::BIT_CYCLES;
  logic       clk_sys;
  logic       rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx_line;
  logic       tx_pin;
  logic       irq;
  int         miscompares;
  int         check_count;

  serial_status_two u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_pin(rx_line), .tx_pin(tx_pin), .irq(irq));
  serial_node u_node (.line(rx_line));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : chk_rd
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : ticks

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_access;
    chk_rd(4'h0, 8'h00);
    wr(4'h0, 8'hEF);
    chk_rd(4'h0, 8'h0E);
    wr(4'h0, 8'h00);
    chk_rd(4'hF, 8'h00);
  endtask : t_access
  task automatic t_frame;
    fork
      u_node.send_frame(8'h55);
      begin
        ticks(3 * BIT);
        chk_rd(4'h0, 8'h41);
      end
    join
    ticks(11 * BIT);
    chk_rd(4'h3, 8'h05);
    chk_rd(4'h0, 8'h40);
    wr(4'h0, 8'h00);
    chk_rd(4'h0, 8'h40);
    wr(4'h0, 8'h40);
    chk_rd(4'h0, 8'h00);
    chk_rd(4'h2, 8'h55);
    chk_rd(4'h3, 8'h00);
  endtask : t_frame
  task automatic t_break;
    wr(4'h6, 8'h01);
    wr(4'h0, 8'h02);
    wr(4'h1, 8'h02);
    u_node.send_low(12);
    ticks(11 * BIT);
    chk_rd(4'h0, 8'hC2);
    chk_rd(4'h3, 8'h00);
    chk_rd(4'h1, 8'h00);
    chk({7'h00, irq}, 8'h01);
    wr(4'h0, 8'hC2);
    chk_rd(4'h0, 8'h02);
    wr(4'h5, 8'h01);
    ticks(2);
    chk({7'h00, irq}, 8'h00);
  endtask : t_break
  task automatic t_tx_break;
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h04);
    ticks(2);
    chk({7'h00, tx_pin}, 8'h00);
    ticks(13 * BIT - 6);
    chk({7'h00, tx_pin}, 8'h00);
    ticks(8);
    chk({7'h00, tx_pin}, 8'h01);
  endtask : t_tx_break
  // Inverted line idles low; turning inversion on first gives one false edge
  task automatic t_invert;
    wr(4'h0, 8'h10);
    fork
      u_node.send_low(3);
      begin
        ticks(BIT);
        wr(4'h0, 8'h50);
        chk_rd(4'h0, 8'h10);
      end
    join
    ticks(BIT);
    chk_rd(4'h0, 8'h51);
  endtask : t_invert

  task automatic complete_run;
    $display("miscompares=%0d check_count=%0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial begin
    {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 14'h0000};
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_access;
    t_frame;
    t_break;
    t_tx_break;
    t_invert;
    complete_run;
  end

  // Run needs about 64k cycles; give headroom
  initial begin
    #(90000 * 50);
    miscompares++;
    complete_run;
  end
endmodule : serial_status_two_bench
